// ===== common/wdmp_regs.vh
// Register map, field positions, reset values and timing figures of the
// watchdog mode and prescale control block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
`ifndef WDMP_REGS_VH
`define WDMP_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WDMP_ADDR_W          5
`define WDMP_OFS_CTRL        5'h00
`define WDMP_OFS_CAUSE       5'h04
`define WDMP_OFS_EVT_STAT    5'h08
`define WDMP_OFS_EVT_MASK    5'h0C

// ----------------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------------
`define WDMP_CTRL_IRQ_FLAG   7
`define WDMP_CTRL_IRQ_EN     6
`define WDMP_CTRL_PRE_HI     5
`define WDMP_CTRL_CHG_EN     4
`define WDMP_CTRL_RST_EN     3
`define WDMP_CTRL_PRE_LO_MSB 2
`define WDMP_CTRL_PRE_LO_LSB 0

// Reset cause register field.
`define WDMP_CAUSE_WD_RST    3

// Event status and mask fields.
`define WDMP_EVT_TIMEOUT_IRQ 0
`define WDMP_EVT_SYS_RESET   1
`define WDMP_EVT_W           2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WDMP_PRE_RESET       4'h0
`define WDMP_EVT_MASK_RESET  2'h0
`define WDMP_WINDOW_W        4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Change enable lives for this many system clock cycles after its write.
`define WDMP_CHG_WINDOW      4'h4
// Shortest time-out in watchdog oscillator cycles, code 0.
`define WDMP_TMO_BASE        21'h0_0800
// Highest defined prescale code; codes above it are reserved.
`define WDMP_PRE_MAX         4'h9
`define WDMP_CNT_W           21

// AXI responses.
`define WDMP_RESP_OKAY       2'h0
`define WDMP_RESP_SLVERR     2'h2

`endif

// ===== rtl/wdmp_timeout_counter.v
// Watchdog time-out counter, stepped by oscillator ticks.
// Assumes osc_tick is a one-cycle pulse already in the aclk domain.
`timescale 1ns/100ps
`include "wdmp_regs.vh"

module wdmp_timeout_counter #(
  parameter CNT_W = `WDMP_CNT_W
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Control
  input  wire             osc_tick,
  input  wire             run,
  input  wire             restart,
  input  wire [3:0]       prescale_sel,
  // Result
  output reg              timeout
);

  reg  [CNT_W-1:0] count;
  wire [CNT_W-1:0] limit;

  // Turns a prescale code into a tick count; reserved codes clamp to the top.
  function [CNT_W-1:0] tmo_limit;
    input [3:0] sel;
    reg   [3:0] s;
    begin
      s = (sel > `WDMP_PRE_MAX) ? `WDMP_PRE_MAX : sel;
      tmo_limit = `WDMP_TMO_BASE << s;
    end
  endfunction

  assign limit = tmo_limit(prescale_sel);

  // Counts ticks while running, wraps and pulses at the selected time-out.
  always @(posedge aclk) begin
    timeout <= 1'b0;
    if (!aresetn || !run || restart) begin
      count <= {CNT_W{1'b0}};
    end else if (osc_tick) begin
      if (count >= limit - 1'b1) begin
        count   <= {CNT_W{1'b0}};
        timeout <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// ===== rtl/wdmp_watchdog_ctrl.v
// Watchdog mode decode, timed change sequence and prescale control with
// an AXI4-Lite register slave and a masked event interrupt.
// Assumes osc_clk_pin and always_on_fuse are asynchronous levels; the
// vector, restart and global enable inputs come from aclk logic.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "wdmp_regs.vh"

module wdmp_watchdog_ctrl #(
  parameter ADDR_W    = `WDMP_ADDR_W,
  parameter CHG_WIN   = `WDMP_CHG_WINDOW
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Processor side
  input  wire              cpu_global_irq_en,
  input  wire              wdt_vector_ack,
  input  wire              wdt_restart,
  output reg               wdt_irq_req,
  output reg               sys_reset_req,
  // Pins and fuse
  input  wire              osc_clk_pin,
  input  wire              always_on_fuse,
  // Event interrupt
  output reg               irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [2:0]                osc_sync;
  reg  [1:0]                fuse_sync;
  reg                       aw_held;
  reg                       w_held;
  reg  [ADDR_W-1:0]         aw_addr;
  reg  [7:0]                w_byte;
  reg                       w_lane0;
  reg                       wd_irq_flag;
  reg                       wd_irq_enable;
  reg                       wd_change_enable;
  reg  [`WDMP_WINDOW_W-1:0] chg_count;
  reg                       wd_reset_enable;
  reg  [3:0]                wd_prescale_sel;
  reg                       wd_reset_flag;
  reg  [`WDMP_EVT_W-1:0]    evt_stat;
  reg  [`WDMP_EVT_W-1:0]    evt_mask;
  wire                      osc_tick;
  wire                      fuse_programmed;
  wire                      rst_en_eff;
  wire                      irq_en_eff;
  wire                      timeout;
  wire                      tmo_irq;
  wire                      tmo_rst;
  wire                      wr_go;
  wire                      ctrl_wr;
  wire                      cause_wr;
  wire                      mask_wr;
  wire                      rd_go;
  wire                      stat_rd;
  wire [7:0]                ctrl_view;
  wire [`WDMP_EVT_W-1:0]    evt_set;

  // Decodes a byte address into a register select; 0 means unmapped.
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `WDMP_OFS_CTRL:     reg_sel = 3'h1;
        `WDMP_OFS_CAUSE:    reg_sel = 3'h2;
        `WDMP_OFS_EVT_STAT: reg_sel = 3'h3;
        `WDMP_OFS_EVT_MASK: reg_sel = 3'h4;
        default:            reg_sel = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // The oscillator pin passes two flops, the third flop only detects edges.
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync  <= 3'h0;
      fuse_sync <= 2'h3;
    end else begin
      osc_sync  <= {osc_sync[1:0], osc_clk_pin};
      fuse_sync <= {fuse_sync[0], always_on_fuse};
    end
  end

  assign osc_tick        = osc_sync[1] & ~osc_sync[2];
  assign fuse_programmed = ~fuse_sync[1];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // A programmed fuse locks reset on and interrupt off; the reset flag
  // holds reset enable high.
  assign rst_en_eff = wd_reset_enable | wd_reset_flag | fuse_programmed;
  assign irq_en_eff = wd_irq_enable & ~fuse_programmed;

  // Interrupt on time-out unless a flag is already pending in combined mode.
  assign tmo_irq = timeout & irq_en_eff & ~(rst_en_eff & wd_irq_flag);
  // Reset in reset-only mode, or in combined mode with the flag unserviced.
  assign tmo_rst = timeout & rst_en_eff & (~irq_en_eff | wd_irq_flag);

  // Control register as software reads it.
  assign ctrl_view = {wd_irq_flag, irq_en_eff, wd_prescale_sel[3], wd_change_enable,
                      rst_en_eff, wd_prescale_sel[2:0]};

  // ----------------------------------------------------------------------
  // Time-out counter
  // ----------------------------------------------------------------------
  // Runs in every mode but stopped; restarted by software or by a reset.
  wdmp_timeout_counter u_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .osc_tick     (osc_tick),
    .run          (rst_en_eff | irq_en_eff),
    .restart      (wdt_restart | tmo_rst),
    .prescale_sel (wd_prescale_sel),
    .timeout      (timeout)
  );

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign wr_go    = aw_held & w_held & ~s_axi_bvalid;
  assign ctrl_wr  = wr_go & w_lane0 & (reg_sel(aw_addr) == 3'h1);
  assign cause_wr = wr_go & w_lane0 & (reg_sel(aw_addr) == 3'h2);
  assign mask_wr  = wr_go & w_lane0 & (reg_sel(aw_addr) == 3'h4);
  assign rd_go    = s_axi_arvalid & s_axi_arready;
  assign stat_rd  = rd_go & (reg_sel(s_axi_araddr) == 3'h3);

  // Write channels are taken in either order; the response follows both.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WDMP_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_sel(aw_addr) == 3'h0) ? `WDMP_RESP_SLVERR : `WDMP_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read answers one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `WDMP_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `WDMP_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        3'h1:    s_axi_rdata <= {24'h00_0000, ctrl_view};
        3'h2:    s_axi_rdata <= {28'h000_0000, wd_reset_flag, 3'h0};
        3'h3:    s_axi_rdata <= {30'h000_0000, evt_stat};
        3'h4:    s_axi_rdata <= {30'h000_0000, evt_mask};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `WDMP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog control register
  // ----------------------------------------------------------------------
  // A watchdog reset puts the control bits back to their reset state; the
  // reset flag survives and keeps reset enable in force.
  always @(posedge aclk) begin
    if (!aresetn || tmo_rst) begin
      wd_irq_flag      <= 1'b0;
      wd_irq_enable    <= 1'b0;
      wd_change_enable <= 1'b0;
      chg_count        <= {`WDMP_WINDOW_W{1'b0}};
      wd_reset_enable  <= 1'b0;
      wd_prescale_sel  <= `WDMP_PRE_RESET;
    end else begin
      // A time-out sets the flag even in the cycle it is cleared.
      wd_irq_flag <= tmo_irq |
                     (wd_irq_flag & ~(wdt_vector_ack |
                                      (ctrl_wr & w_byte[`WDMP_CTRL_IRQ_FLAG])));
      // Vector execution drops the enable: combined mode falls to reset-only, interrupt mode stops.
      if (ctrl_wr) begin
        wd_irq_enable <= w_byte[`WDMP_CTRL_IRQ_EN] & ~fuse_programmed;
      end else if (wdt_vector_ack) begin
        wd_irq_enable <= 1'b0;
      end
      // Change enable opens a window of a fixed number of cycles.
      if (ctrl_wr) begin
        wd_change_enable <= w_byte[`WDMP_CTRL_CHG_EN];
        chg_count        <= w_byte[`WDMP_CTRL_CHG_EN] ? CHG_WIN[`WDMP_WINDOW_W-1:0] :
                                                        {`WDMP_WINDOW_W{1'b0}};
      end else if (wd_change_enable) begin
        chg_count <= chg_count - 1'b1;
        if (chg_count <= 1) begin
          wd_change_enable <= 1'b0;
        end
      end
      // Setting is free and the reset flag holds the bit set, so clearing the
      // flag alone never stops the watchdog; clearing needs the window.
      if ((ctrl_wr && w_byte[`WDMP_CTRL_RST_EN]) || wd_reset_flag) begin
        wd_reset_enable <= 1'b1;
      end else if (ctrl_wr && wd_change_enable) begin
        wd_reset_enable <= 1'b0;
      end
      // Prescale changes only inside the window.
      if (ctrl_wr && wd_change_enable) begin
        wd_prescale_sel <= {w_byte[`WDMP_CTRL_PRE_HI],
                            w_byte[`WDMP_CTRL_PRE_LO_MSB:`WDMP_CTRL_PRE_LO_LSB]};
      end
    end
  end

  // Reset flag: set by a watchdog reset, cleared by writing zero to it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_reset_flag <= 1'b0;
    end else if (tmo_rst) begin
      wd_reset_flag <= 1'b1;
    end else if (cause_wr && !w_byte[`WDMP_CAUSE_WD_RST]) begin
      wd_reset_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Processor outputs
  // ----------------------------------------------------------------------
  // The vector request needs the flag, its enable and the global enable.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdt_irq_req   <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      wdt_irq_req   <= wd_irq_flag & irq_en_eff & cpu_global_irq_en;
      sys_reset_req <= tmo_rst;
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------
  assign evt_set = {tmo_rst, tmo_irq};

  // Sticky events clear on a status read; a new event wins over the read.
  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat <= {`WDMP_EVT_W{1'b0}};
      evt_mask <= `WDMP_EVT_MASK_RESET;
      irq      <= 1'b0;
    end else begin
      evt_stat <= evt_set | (stat_rd ? {`WDMP_EVT_W{1'b0}} : evt_stat);
      if (mask_wr) begin
        evt_mask <= w_byte[`WDMP_EVT_W-1:0];
      end
      irq <= |(evt_stat & evt_mask);
    end
  end

endmodule

// ===== dv/wdmp_watchdog_ctrl_sva.sv
// Concurrent checks on the ports of the watchdog control block.
// Assumes the single aclk domain and the synchronous active-low reset.
`timescale 1ns/100ps

module wdmp_watchdog_ctrl_sva (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Processor side and fuse
  input wire        cpu_global_irq_en,
  input wire        wdt_vector_ack,
  input wire        wdt_irq_req,
  input wire        sys_reset_req,
  input wire        always_on_fuse
);
  // All checks share one clock and are off during reset.
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_gate_off_a: assert property (!cpu_global_irq_en |=> !wdt_irq_req)
    else $error("interrupt request while global enable is low");
  fuse_blocks_irq_a: assert property ((!always_on_fuse)[*5] |=> !wdt_irq_req)
    else $error("interrupt request with the fuse programmed");
  vector_clears_a: assert property (wdt_vector_ack |-> ##2 !wdt_irq_req)
    else $error("interrupt request survives vector execution");
  reset_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("system reset request longer than one cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule

bind wdmp_watchdog_ctrl wdmp_watchdog_ctrl_sva wdmp_watchdog_ctrl_sva_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_global_irq_en, .wdt_vector_ack,
  .wdt_irq_req, .sys_reset_req, .always_on_fuse);

// ===== dv/wdmp_watchdog_ctrl_tb_top.sv
// Self-checking bench for the watchdog control block.
// Assumes the checker is bound in; bus transfers follow the block's handshakes.
`timescale 1ns/100ps

module wdmp_watchdog_ctrl_tb_top;
  // -------------------------------------------------------------------
  // Signals and table
  // -------------------------------------------------------------------
  localparam int CHG_WIN = 4;
  localparam int TMO     = 8192;  // Code 0: 2048 ticks, one tick per 4 aclk.
  typedef struct packed {logic [4:0] a; logic [31:0] d; logic [31:0] e; logic [31:0] r;} wdmp_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cpu_global_irq_en, wdt_vector_ack;
  logic        wdt_restart, wdt_irq_req, sys_reset_req, osc_clk_pin, always_on_fuse, irq;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rsp, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt, num_checks, n;
  // Write, then read back: address, data, read value, response.
  wdmp_row_t rows [7] = '{'{5'h00, 32'h40, 32'h40, 32'h0}, '{5'h00, 32'h08, 32'h08, 32'h0},
    '{5'h00, 32'h00, 32'h08, 32'h0}, '{5'h00, 32'h21, 32'h08, 32'h0},
    '{5'h04, 32'h00, 32'h00, 32'h0}, '{5'h0C, 32'h02, 32'h02, 32'h0},
    '{5'h10, 32'h5A, 32'h00, 32'h2}};

  wdmp_watchdog_ctrl #(.CHG_WIN(CHG_WIN)) wdmp_watchdog_ctrl_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_global_irq_en, .wdt_vector_ack, .wdt_restart,
    .wdt_irq_req, .sys_reset_req, .osc_clk_pin, .always_on_fuse, .irq);

  // -------------------------------------------------------------------
  // Clocks and tasks
  // -------------------------------------------------------------------
  // System clock, then a watchdog oscillator four aclk periods long.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    osc_clk_pin = 1'b0;
    forever begin
      repeat (2) @(posedge aclk);
      osc_clk_pin <= ~osc_clk_pin;
    end
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write; address and data are offered together and held until taken.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 40);
    r = {30'h0, s_axi_bresp};
    s_axi_bready <= 1'b0;
    chk(k < 40, 32'h1);
  endtask

  // Bus read; the address is held until taken, data kept at the answer edge.
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 40);
    rd = s_axi_rdata;
    rsp = {30'h0, s_axi_rresp};
    s_axi_rready <= 1'b0;
    chk(rd, e);
  endtask

  // Waits for the interrupt request or, with rs set, the system reset request.
  task automatic wait_ev(input bit rs);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(rs ? sys_reset_req : wdt_irq_req) && n < TMO + 100);
    chk({31'h0, rs ? sys_reset_req : wdt_irq_req}, 32'h1);
  endtask

  // One-cycle pulse on the vector acknowledge or, with rs set, the restart.
  task automatic pulse(input bit rs);
    @(posedge aclk);
    if (rs) wdt_restart <= 1'b1;
    else wdt_vector_ack <= 1'b1;
    @(posedge aclk);
    wdt_restart <= 1'b0;
    wdt_vector_ack <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------------
  // Watchdog against a hang of the bench.
  initial begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_global_irq_en, wdt_vector_ack, wdt_restart} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    always_on_fuse = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) rc(a[4:0], 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rsp);
      chk(rsp, rows[i].r);
      rc(rows[i].a, rows[i].e);
      chk(rsp, rows[i].r);
    end
    $display("test register table done");
    wr(5'h00, 32'h18, rsp);
    wr(5'h00, 32'h21, rsp);
    rc(5'h00, 32'h21);
    wr(5'h00, 32'h10, rsp);
    rc(5'h00, 32'h31);
    repeat (CHG_WIN) @(posedge aclk);
    rc(5'h00, 32'h21);
    wr(5'h00, 32'h18, rsp);
    wr(5'h00, 32'h00, rsp);
    rc(5'h00, 32'h00);
    $display("test timed change done");
    cpu_global_irq_en <= 1'b1;
    wr(5'h00, 32'h40, rsp);
    wait_ev(0);
    chk(n > TMO - 24 && n < TMO + 24, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(5'h0C, 32'h03, rsp);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    cpu_global_irq_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, wdt_irq_req}, 32'h0);
    cpu_global_irq_en <= 1'b1;
    rc(5'h00, 32'hC0);
    pulse(0);
    rc(5'h00, 32'h00);
    rc(5'h08, 32'h01);
    rc(5'h08, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(5'h00, 32'h40, rsp);
    repeat (6000) @(posedge aclk);
    pulse(1);
    wait_ev(0);
    chk(n > TMO - 40, 32'h1);
    wr(5'h00, 32'hC0, rsp);
    rc(5'h00, 32'h40);
    rc(5'h08, 32'h01);
    $display("test interrupt mode done");
    wr(5'h00, 32'h48, rsp);
    pulse(1);
    wait_ev(0);
    pulse(0);
    rc(5'h00, 32'h08);
    wr(5'h00, 32'h48, rsp);
    wait_ev(0);
    wait_ev(1);
    chk(n > TMO - 40, 32'h1);
    rc(5'h04, 32'h08);
    rc(5'h00, 32'h08);
    chk({31'h0, irq}, 32'h1);
    rc(5'h08, 32'h03);
    wr(5'h00, 32'h18, rsp);
    wr(5'h00, 32'h00, rsp);
    rc(5'h00, 32'h08);
    wr(5'h04, 32'h00, rsp);
    rc(5'h00, 32'h08);
    wr(5'h00, 32'h18, rsp);
    wr(5'h00, 32'h00, rsp);
    rc(5'h00, 32'h00);
    repeat (TMO + 100) @(posedge aclk);
    rc(5'h08, 32'h00);
    $display("test combined mode done");
    always_on_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(5'h00, 32'h40, rsp);
    rc(5'h00, 32'h08);
    always_on_fuse <= 1'b1;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(5'h00, 32'h00);
    rc(5'h04, 32'h00);
    $display("test fuse and reset done");
    report_and_stop;
  end
endmodule
